/* core/ssb_defs.svh */
// Register map, field positions, reset values and timing constants of the sequencer bridge
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

`define SSB_DEV_ADDR        7'h0C
`define SSB_REG_STEP        8'h00
`define SSB_REG_CONFIG      8'h01
`define SSB_REG_SHUTTER     8'h02
`define SSB_REG_CURRENT     8'h03

`define SSB_STEP_DIR_BIT    0
`define SSB_STEP_ON_BIT     1
`define SSB_STEP_CRST_BIT   2
`define SSB_STEP_CNT_LSB    3
`define SSB_STEP_CNT_MSB    7
`define SSB_CFG_HOLD_LSB    0
`define SSB_CFG_HOLD_MSB    2
`define SSB_CFG_HALF_BIT    3
`define SSB_CFG_DPOS_BIT    4
`define SSB_CFG_EXT_BIT     5
`define SSB_FLAG_BUSY_BIT   7
`define SSB_SH_MODE_LSB     0
`define SSB_SH_MODE_MSB     1
`define SSB_SH_EN_BIT       2
`define SSB_CUR_MSB         3

`define SSB_RST_STEP        8'h00
`define SSB_RST_CONFIG      6'h00
`define SSB_RST_SHUTTER     3'h0
`define SSB_RST_CURRENT     4'h0

`define SSB_STEP_EXTRA      8'h40
`define SSB_PHASE_DEFAULT   4'b1010

`define SSB_CLK_MHZ         40
`define SSB_LF_STEP_US      2000
`define SSB_DP_STEP_US      10000
`define SSB_LF_STEP_CYC     (`SSB_LF_STEP_US * `SSB_CLK_MHZ)
`define SSB_DP_STEP_CYC     (`SSB_DP_STEP_US * `SSB_CLK_MHZ)

`endif

/* core/ssb_pkg.sv */
// Types shared by the sequencer bridge modules
package ssb_pkg;
  typedef enum logic [2:0] {
    SSB_I2C_IDLE  = 3'b000,
    SSB_I2C_DEV   = 3'b001,
    SSB_I2C_REG   = 3'b010,
    SSB_I2C_WDATA = 3'b011,
    SSB_I2C_RDATA = 3'b100
  } ssb_i2c_state_t;

  typedef enum logic [1:0] {
    SSB_SEQ_IDLE  = 2'b00,
    SSB_SEQ_HOLD1 = 2'b01,
    SSB_SEQ_STEP  = 2'b10,
    SSB_SEQ_HOLD2 = 2'b11
  } ssb_seq_state_t;
endpackage

/* core/ssb_if.sv */
// Register access carrier between the serial slave and the register file
`timescale 1ns/1ps
interface ssb_reg_if;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport slave (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport regs  (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* core/ssb_i2c_slave.sv */
// Serial two-wire slave: device address, register pointer, data with auto-increment
`timescale 1ns/1ps
`include "ssb_defs.svh"
module ssb_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = `SSB_DEV_ADDR
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_oe,
  ssb_reg_if.slave   bus
);
  logic [1:0]             scl_meta_reg;
  logic [1:0]             sda_meta_reg;
  logic                   scl_d_reg;
  logic                   sda_d_reg;
  ssb_pkg::ssb_i2c_state_t state_reg;
  logic [3:0]             bit_cnt_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             tx_reg;
  logic [7:0]             ptr_reg;
  logic                   ack_reg;
  logic                   wr_stb_reg;
  logic [7:0]             wr_addr_reg;
  logic [7:0]             wr_data_reg;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_cond;
  logic                   stop_cond;
  logic [7:0]             byte_in;

  assign bus.wr_stb  = wr_stb_reg;
  assign bus.wr_addr = wr_addr_reg;
  assign bus.wr_data = wr_data_reg;
  assign bus.rd_addr = ptr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the second stage and a delayed copy of it are read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_meta_reg <= 2'b11;
      sda_meta_reg <= 2'b11;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      scl_d_reg    <= scl_meta_reg[1];
      sda_d_reg    <= sda_meta_reg[1];
    end
  end

  assign scl_rise   = scl_meta_reg[1] & ~scl_d_reg;
  assign scl_fall   = ~scl_meta_reg[1] & scl_d_reg;
  assign start_cond = scl_meta_reg[1] & scl_d_reg & sda_d_reg & ~sda_meta_reg[1];
  assign stop_cond  = scl_meta_reg[1] & scl_d_reg & ~sda_d_reg & sda_meta_reg[1];
  assign byte_in    = {shift_reg[6:0], sda_meta_reg[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ssb_pkg::SSB_I2C_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      ack_reg     <= 1'b0;
      sda_oe      <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (start_cond) begin
        state_reg   <= ssb_pkg::SSB_I2C_DEV;
        bit_cnt_reg <= 4'h0;
        ack_reg     <= 1'b0;
        sda_oe      <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ssb_pkg::SSB_I2C_IDLE;
        sda_oe    <= 1'b0;
      end else if (state_reg != ssb_pkg::SSB_I2C_IDLE && scl_rise) begin
        bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
        if (bit_cnt_reg < 4'h8) begin
          shift_reg <= byte_in;
        end
        if (bit_cnt_reg == 4'h7) begin
          ack_reg <= 1'b1;
          unique case (state_reg)
            ssb_pkg::SSB_I2C_DEV: begin
              if (byte_in[7:1] == DEV_ADDR) begin
                state_reg <= byte_in[0] ? ssb_pkg::SSB_I2C_RDATA : ssb_pkg::SSB_I2C_REG;
              end else begin
                state_reg <= ssb_pkg::SSB_I2C_IDLE;
                ack_reg   <= 1'b0;
              end
            end
            ssb_pkg::SSB_I2C_REG: begin
              ptr_reg   <= byte_in;
              state_reg <= ssb_pkg::SSB_I2C_WDATA;
            end
            ssb_pkg::SSB_I2C_WDATA: begin
              wr_stb_reg  <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= byte_in;
              ptr_reg     <= ptr_reg + 8'h01;
            end
            ssb_pkg::SSB_I2C_RDATA: begin
              ack_reg <= 1'b0;
            end
            default: begin
              ack_reg <= 1'b0;
            end
          endcase
        end
        // The acknowledge after the address byte is our own; only the host's advances the pointer
        if (bit_cnt_reg == 4'h8 && state_reg == ssb_pkg::SSB_I2C_RDATA && !ack_reg) begin
          if (sda_meta_reg[1]) begin
            state_reg <= ssb_pkg::SSB_I2C_IDLE;
          end else begin
            ptr_reg <= ptr_reg + 8'h01;
          end
        end
      end else if (state_reg != ssb_pkg::SSB_I2C_IDLE && scl_fall) begin
        if (bit_cnt_reg == 4'h8) begin
          sda_oe <= ack_reg;
        end else if (state_reg == ssb_pkg::SSB_I2C_RDATA && bit_cnt_reg == 4'h0) begin
          sda_oe <= ~bus.rd_data[7];
          tx_reg <= {bus.rd_data[6:0], 1'b0};
        end else if (state_reg == ssb_pkg::SSB_I2C_RDATA) begin
          sda_oe <= ~tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end
endmodule

/* core/ssb_top.sv */
// Focus stepper sequencer and shutter bridge control with serial register access
`timescale 1ns/1ps
`include "ssb_defs.svh"
module ssb_top #(
  parameter logic [6:0] DEV_ADDR    = `SSB_DEV_ADDR,
  parameter int         LF_STEP_CYC = `SSB_LF_STEP_CYC,
  parameter int         DP_STEP_CYC = `SSB_DP_STEP_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             motor_phase_a_pos,
  output logic             motor_phase_a_neg,
  output logic             motor_phase_b_pos,
  output logic             motor_phase_b_neg,
  output logic             bridge_output_a,
  output logic             bridge_output_a_oe,
  output logic             bridge_output_b,
  output logic             bridge_output_b_oe,
  output logic             bridge_regulate,
  output logic [3:0]       drive_current_code,
  output logic             sequence_busy_flag
);
  localparam int TICK_W = 24;

  if (LF_STEP_CYC < 4 || DP_STEP_CYC < 4 || LF_STEP_CYC >= (1 << TICK_W) || DP_STEP_CYC >= (1 << TICK_W)) begin : g_chk
    $error("Step period out of range");
  end

  ssb_reg_if               rif ();
  logic [7:0]              step_reg;
  logic [5:0]              config_reg;
  logic [2:0]              shutter_reg;
  logic [3:0]              current_reg;
  ssb_pkg::ssb_seq_state_t seq_state_reg;
  logic                    dpos_reg;
  logic [TICK_W-1:0]       tick_cnt_reg;
  logic [TICK_W-1:0]       tick_period;
  logic                    tick;
  logic [7:0]              cnt_reg;
  logic [2:0]              phase_idx_reg;
  logic [2:0]              phase_next;
  logic [3:0]              phase_reg;
  logic [7:0]              step_total;
  logic [7:0]              hold_total;
  logic                    wr_step;
  logic                    start_lf;
  logic                    start_dp;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic [7:0] hold_pulses(input logic [2:0] code);
    unique case (code)
      3'h0:    hold_pulses = 8'h01;
      3'h1:    hold_pulses = 8'h02;
      3'h2:    hold_pulses = 8'h04;
      3'h3:    hold_pulses = 8'h05;
      3'h4:    hold_pulses = 8'h08;
      3'h5:    hold_pulses = 8'h10;
      3'h6:    hold_pulses = 8'h20;
      default: hold_pulses = 8'h01;
    endcase
  endfunction

  // Phase pattern {a_pos, a_neg, b_pos, b_neg}; even entries form the full-step cycle
  function automatic logic [3:0] phase_pattern(input logic [2:0] idx);
    unique case (idx)
      3'h0:    phase_pattern = 4'b1010;
      3'h1:    phase_pattern = 4'b0010;
      3'h2:    phase_pattern = 4'b0110;
      3'h3:    phase_pattern = 4'b0100;
      3'h4:    phase_pattern = 4'b0101;
      3'h5:    phase_pattern = 4'b0001;
      3'h6:    phase_pattern = 4'b1001;
      default: phase_pattern = 4'b1000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  ssb_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk      (clk),
    .reset_n  (reset_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe   (sda_oe),
    .bus      (rif.slave)
  );

  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  assign wr_step  = rif.wr_stb && rif.wr_addr == `SSB_REG_STEP;
  assign start_dp = wr_step && seq_state_reg == ssb_pkg::SSB_SEQ_IDLE && config_reg[`SSB_CFG_DPOS_BIT];
  assign start_lf = wr_step && seq_state_reg == ssb_pkg::SSB_SEQ_IDLE && !config_reg[`SSB_CFG_DPOS_BIT]
                    && rif.wr_data[`SSB_STEP_ON_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_reg    <= `SSB_RST_STEP;
      config_reg  <= `SSB_RST_CONFIG;
      shutter_reg <= `SSB_RST_SHUTTER;
      current_reg <= `SSB_RST_CURRENT;
    end else if (rif.wr_stb) begin
      unique case (rif.wr_addr)
        `SSB_REG_STEP:    step_reg    <= rif.wr_data;
        `SSB_REG_CONFIG:  config_reg  <= rif.wr_data[5:0];
        `SSB_REG_SHUTTER: shutter_reg <= rif.wr_data[2:0];
        `SSB_REG_CURRENT: current_reg <= rif.wr_data[3:0];
        default:          current_reg <= current_reg;
      endcase
    end
  end

  always_comb begin
    unique case (rif.rd_addr)
      `SSB_REG_STEP:    rif.rd_data = step_reg;
      `SSB_REG_CONFIG:  rif.rd_data = {sequence_busy_flag, 1'b0, config_reg};
      `SSB_REG_SHUTTER: rif.rd_data = {5'h00, shutter_reg};
      `SSB_REG_CURRENT: rif.rd_data = {4'h0, current_reg};
      default:          rif.rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step clock divider; half-step mode halves the period
  always_comb begin
    tick_period = dpos_reg ? DP_STEP_CYC[TICK_W-1:0] : LF_STEP_CYC[TICK_W-1:0];
    if (config_reg[`SSB_CFG_HALF_BIT]) begin
      tick_period = {1'b0, tick_period[TICK_W-1:1]};
    end
  end

  assign tick = tick_cnt_reg == tick_period - 24'h00_0001;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= '0;
    end else if (seq_state_reg == ssb_pkg::SSB_SEQ_IDLE || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign step_total = {2'b00, step_reg[`SSB_STEP_CNT_MSB:`SSB_STEP_CNT_LSB], 1'b0} + 8'h02
                      + (config_reg[`SSB_CFG_EXT_BIT] ? `SSB_STEP_EXTRA : 8'h00);
  assign hold_total = hold_pulses(config_reg[`SSB_CFG_HOLD_MSB:`SSB_CFG_HOLD_LSB]);

  always_comb begin
    if (config_reg[`SSB_CFG_HALF_BIT]) begin
      phase_next = step_reg[`SSB_STEP_DIR_BIT] ? phase_idx_reg - 3'h1 : phase_idx_reg + 3'h1;
    end else begin
      phase_next = step_reg[`SSB_STEP_DIR_BIT] ? phase_idx_reg - 3'h2 : phase_idx_reg + 3'h2;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_state_reg      <= ssb_pkg::SSB_SEQ_IDLE;
      dpos_reg           <= 1'b0;
      cnt_reg            <= 8'h00;
      phase_idx_reg      <= 3'h0;
      phase_reg          <= 4'h0;
      sequence_busy_flag <= 1'b0;
    end else begin
      unique case (seq_state_reg)
        ssb_pkg::SSB_SEQ_IDLE: begin
          if (start_lf || start_dp) begin
            seq_state_reg      <= ssb_pkg::SSB_SEQ_HOLD1;
            dpos_reg           <= start_dp;
            cnt_reg            <= hold_total;
            phase_idx_reg      <= 3'h0;
            phase_reg          <= `SSB_PHASE_DEFAULT;
            sequence_busy_flag <= 1'b1;
          end
        end
        ssb_pkg::SSB_SEQ_HOLD1: begin
          if (tick) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
              seq_state_reg <= ssb_pkg::SSB_SEQ_STEP;
              cnt_reg       <= step_total;
            end
          end
        end
        ssb_pkg::SSB_SEQ_STEP: begin
          if (tick) begin
            phase_idx_reg <= phase_next;
            phase_reg     <= phase_pattern(phase_next);
            cnt_reg       <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
              seq_state_reg <= ssb_pkg::SSB_SEQ_HOLD2;
              cnt_reg       <= hold_total;
            end
          end
        end
        ssb_pkg::SSB_SEQ_HOLD2: begin
          if (tick) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
              seq_state_reg      <= ssb_pkg::SSB_SEQ_IDLE;
              phase_reg          <= 4'h0;
              sequence_busy_flag <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  assign motor_phase_a_pos = phase_reg[3];
  assign motor_phase_a_neg = phase_reg[2];
  assign motor_phase_b_pos = phase_reg[1];
  assign motor_phase_b_neg = phase_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Shutter bridge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_output_a    <= 1'b0;
      bridge_output_b    <= 1'b0;
      bridge_output_a_oe <= 1'b0;
      bridge_output_b_oe <= 1'b0;
      bridge_regulate    <= 1'b0;
      drive_current_code <= `SSB_RST_CURRENT;
    end else begin
      drive_current_code <= current_reg;
      if (!shutter_reg[`SSB_SH_EN_BIT]) begin
        bridge_output_a    <= 1'b0;
        bridge_output_b    <= 1'b0;
        bridge_output_a_oe <= 1'b0;
        bridge_output_b_oe <= 1'b0;
        bridge_regulate    <= 1'b0;
      end else begin
        unique case (shutter_reg[`SSB_SH_MODE_MSB:`SSB_SH_MODE_LSB])
          2'b00: {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a, bridge_output_b} <= 4'b0000;
          2'b01: {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a, bridge_output_b} <= 4'b1110;
          2'b10: {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a, bridge_output_b} <= 4'b1101;
          2'b11: {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a, bridge_output_b} <= 4'b1100;
        endcase
        bridge_regulate <= shutter_reg[0] ^ shutter_reg[1];
      end
    end
  end
endmodule

/* dv/ssb_top_monitor.sv */
// Port-level checker of the sequencer bridge, bound to the top module
`timescale 1ns/1ps
module ssb_top_monitor #(
  parameter int LF_STEP_CYC = 80000
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       motor_phase_a_pos,
  input wire logic       motor_phase_a_neg,
  input wire logic       motor_phase_b_pos,
  input wire logic       motor_phase_b_neg,
  input wire logic       bridge_output_a,
  input wire logic       bridge_output_a_oe,
  input wire logic       bridge_output_b,
  input wire logic       bridge_output_b_oe,
  input wire logic       bridge_regulate,
  input wire logic [3:0] drive_current_code,
  input wire logic       sequence_busy_flag
);
  localparam int MIN_GAP = LF_STEP_CYC / 2 - 1;
  logic [3:0]  ph;
  logic [3:0]  ph_reg;
  logic [19:0] gap_reg;
  logic        ph_chg;
  logic        drv_ab;
  assign ph = {motor_phase_a_pos, motor_phase_a_neg, motor_phase_b_pos, motor_phase_b_neg};
  assign ph_chg = (ph != ph_reg);
  assign drv_ab = bridge_output_a_oe && bridge_output_b_oe && (bridge_output_a ^ bridge_output_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last phase change, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg  <= 4'h0;
      gap_reg <= 20'h0_0000;
    end else begin
      ph_reg <= ph;
      if (ph_chg) gap_reg <= 20'h0_0000;
      else if (gap_reg != 20'hF_FFFF) gap_reg <= gap_reg + 20'h0_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_begin;
    $rose(sequence_busy_flag);
  endsequence
  sequence s_run;
    (ph == 4'b1010) ##1 sequence_busy_flag [*2];
  endsequence
  property p_start;
    s_begin |-> s_run;
  endproperty
  AST_BUSY_IDLE_PH: assert property (!sequence_busy_flag |-> ph == 4'h0)
    else $error("phase outputs active while idle");
  AST_START_PH: assert property (p_start)
    else $error("sequence start pattern wrong");
  AST_END_PH: assert property ($fell(sequence_busy_flag) |-> ph == 4'h0)
    else $error("phases not released at sequence end");
  AST_STEP_GAP: assert property (ph_chg && $past(sequence_busy_flag) |-> gap_reg >= MIN_GAP)
    else $error("step pulses too close");
  AST_STEP_ADJ: assert property (ph_chg && sequence_busy_flag && $past(sequence_busy_flag)
    |-> $countones(ph ^ ph_reg) inside {1, 2} && $countones(ph) inside {1, 2})
    else $error("phase step skips a pattern");
  AST_OE_PAIR: assert property (bridge_output_a_oe == bridge_output_b_oe)
    else $error("bridge outputs not released together");
  AST_REG_DRIVE: assert property (bridge_regulate |-> drv_ab)
    else $error("regulation without conduction");
  AST_DRIVE_REG: assert property (drv_ab |-> bridge_regulate)
    else $error("conduction without regulation");
endmodule

bind ssb_top ssb_top_monitor #(.LF_STEP_CYC(LF_STEP_CYC)) u_mon (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .motor_phase_a_pos(motor_phase_a_pos), .motor_phase_a_neg(motor_phase_a_neg),
  .motor_phase_b_pos(motor_phase_b_pos), .motor_phase_b_neg(motor_phase_b_neg),
  .bridge_output_a(bridge_output_a), .bridge_output_a_oe(bridge_output_a_oe),
  .bridge_output_b(bridge_output_b), .bridge_output_b_oe(bridge_output_b_oe),
  .bridge_regulate(bridge_regulate), .drive_current_code(drive_current_code),
  .sequence_busy_flag(sequence_busy_flag));

/* dv/ssb_host_model.sv */
// Two-wire bus host model driving the serial pins of the bridge
`timescale 1ns/1ps
module ssb_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h0C
) (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output wire logic sda
);
  logic low_reg;
  // Pulled-up wire: low when either party pulls
  assign sda = !(low_reg || sda_oe);
  initial begin
    scl = 1'b1;
    low_reg = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start_cond();
    low_reg <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    low_reg <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic stop_cond();
    low_reg <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    low_reg <= 1'b0;
    wt(4);
  endtask
  task automatic bit_out(input logic b);
    low_reg <= !b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic bit_in(output logic b);
    low_reg <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(2);
    b = sda;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    ack = !a;
  endtask
  // Register write: address, pointer, one data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send({dev, 1'b0}, a0);
    send(r, a1);
    send(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // Register read with repeated start, one byte closed by no-acknowledge
  task automatic read_reg(input logic [7:0] r, output logic [7:0] d);
    logic a;
    start_cond();
    send({DEV_ADDR, 1'b0}, a);
    send(r, a);
    start_cond();
    send({DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop_cond();
  endtask
endmodule

/* dv/stepper_sequencer_bridge_ctrl_bench.sv */
// Self-checking bench of the sequencer bridge
`timescale 1ns/1ps
`include "ssb_defs.svh"
module stepper_sequencer_bridge_ctrl_bench;
  localparam int LF = 40;
  localparam int DP = 80;
  logic       clk;
  logic       reset_n;
  logic       scl;
  wire        sda;
  logic       sda_out, sda_oe, bridge_regulate, sequence_busy_flag;
  logic       a_pos, a_neg, b_pos, b_neg;
  logic       out_a, out_a_oe, out_b, out_b_oe;
  logic [3:0] drive_current_code;
  logic [3:0] ph, ph_prev;
  logic       busy_prev;
  logic [3:0] ph_q[$];
  int         busy_cyc, cyc_cnt, n_errors, compares;
  // Rows: bridge register, current code, expected {a, a_oe, b, b_oe, regulate}
  logic [19:0] rows [5] = '{20'h0_1000, 20'h0_4500, 20'h0_5F1B, 20'h0_6A0F, 20'h0_730A};

  ssb_top #(.LF_STEP_CYC(LF), .DP_STEP_CYC(DP)) dut (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .motor_phase_a_pos(a_pos), .motor_phase_a_neg(a_neg), .motor_phase_b_pos(b_pos), .motor_phase_b_neg(b_neg),
    .bridge_output_a(out_a), .bridge_output_a_oe(out_a_oe), .bridge_output_b(out_b),
    .bridge_output_b_oe(out_b_oe), .bridge_regulate(bridge_regulate),
    .drive_current_code(drive_current_code), .sequence_busy_flag(sequence_busy_flag));
  ssb_host_model #(.DEV_ADDR(`SSB_DEV_ADDR)) host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  assign ph = {a_pos, a_neg, b_pos, b_neg};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Records each phase change of a running sequence and counts busy cycles
  always @(posedge clk) begin
    if (busy_prev === 1'b1 && ph !== ph_prev) ph_q.push_back(ph);
    if (sequence_busy_flag === 1'b1) busy_cyc++;
    busy_prev = sequence_busy_flag;
    ph_prev = ph;
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Runs one sequence; mid other than zero reads the flag register while busy
  task automatic run_seq(input logic [7:0] cfg, input logic [7:0] stp, input int cyc, input logic [47:0] pats,
                         input int n, input logic [7:0] mid);
    logic       ok;
    logic [7:0] d;
    int         i;
    host.write_reg(`SSB_DEV_ADDR, 8'h01, cfg, ok);
    ph_q.delete();
    busy_cyc = 0;
    host.write_reg(`SSB_DEV_ADDR, 8'h00, stp, ok);
    check("busy start", sequence_busy_flag, 1);
    if (mid !== 8'h00) begin
      host.read_reg(8'h01, d);
      check("flag busy", d, mid);
    end
    i = 0;
    while (sequence_busy_flag === 1'b1 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    host.wt(2);
    check("busy cycles", busy_cyc, cyc);
    check("step changes", ph_q.size(), n);
    for (i = 0; i < n && i < 12; i++) check("phase", ph_q[i], pats[47-4*i -: 4]);
    $display("sequence test done cfg %h step %h", cfg, stp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic       ok;
    logic [7:0] d;
    reset_n = 1'b0;
    busy_prev = 1'b0;
    ph_prev = 4'h0;
    {busy_cyc, cyc_cnt, n_errors, compares} = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    host.wt(4);
    check("reset outputs", {ph, out_a, out_a_oe, out_b, out_b_oe, bridge_regulate, drive_current_code, sda_out, sda_oe},
          0);
    check("reset busy", sequence_busy_flag, 0);
    host.read_reg(8'h01, d);
    check("flag idle", d, 8'h00);
    host.read_reg(8'h05, d);
    check("unmapped read", d, 8'h00);
    host.write_reg(7'h0D, 8'h02, 8'h05, ok);
    check("foreign address ack", ok, 0);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      host.write_reg(`SSB_DEV_ADDR, 8'h02, rows[i][19:12], ok);
      check("write ack", ok, 1);
      host.write_reg(`SSB_DEV_ADDR, 8'h03, {4'h0, rows[i][11:8]}, ok);
      check("bridge", {out_a, out_a_oe, out_b, out_b_oe, bridge_regulate}, rows[i][4:0]);
      check("current", drive_current_code, rows[i][11:8]);
      host.read_reg(8'h02, d);
      check("bridge readback", d, rows[i][19:12]);
    end
    $display("bridge table test done");
    // Full step, eight steps clockwise: two whole cycles
    run_seq(8'h00, 8'h1A, 10 * LF, 48'h659A_659A_0000, 9, 8'h00);
    // Half step, four steps counter-clockwise, two hold pulses
    run_seq(8'h09, 8'h0B, 8 * LF / 2, 48'h8915_0000_0000, 5, 8'h00);
    // Default position with extension: 2 + 64 steps, four hold pulses
    run_seq(8'h32, 8'h00, 74 * DP, 48'h659A_659A_659A, 67, 8'hB2);
    host.read_reg(8'h01, d);
    check("flag cleared", d, 8'h32);
    $display("flag clear test done");
    // Reset in the middle of a default-position run
    host.write_reg(`SSB_DEV_ADDR, 8'h00, 8'h00, ok);
    check("busy before reset", sequence_busy_flag, 1);
    reset_n <= 1'b0;
    host.wt(2);
    reset_n <= 1'b1;
    host.wt(4);
    check("mid-run reset", {ph, out_a, out_a_oe, out_b, out_b_oe, bridge_regulate, drive_current_code,
          sequence_busy_flag}, 0);
    host.read_reg(8'h01, d);
    check("config after reset", d, 8'h00);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
